//--- src/acdc_top.sv
// Notes on behaviour
// - Playback interpolation code 0 means 16, other codes mean their value 1 to 15.
// - Playback interpolation applies only while the playback block selection is 0.
// - First divider power bit low powers it down and takes the playback processing clock.
// - First divider code 0 divides by 128, other codes by their value.
// - Modulator divider power bit low powers it down and takes the playback modulator clock.
// - Modulator divider code 0 divides by 128, other codes by their value.
// - Oversampling code 0 means 256, other codes mean their value.
// - Record instruction count is twice the code, 0 to 510.
// - Record instruction count applies only while the record block selection is 0.
// - Record decimation code 0 means 16, other codes mean their value 1 to 15.
// - Record decimation applies only while the record block selection is 0.
`timescale 1ns/100ps
`default_nettype none

module acdc_top (
  input  wire logic        SYS_CLK_IN,
  input  wire logic        RST_IN,
  input  wire logic        PSEL_IN,
  input  wire logic        PENABLE_IN,
  input  wire logic        PWRITE_IN,
  input  wire logic [7:0]  PADDR_IN,
  input  wire logic [31:0] PWDATA_IN,
  output logic [31:0]      PRDATA_OUT,
  output logic             PREADY_OUT,
  output logic             PSLVERR_OUT,
  input  wire logic        CODEC_CLK_EN_IN,
  input  wire logic        PLAYBACK_PROC_EN_IN,
  input  wire logic        PLAYBACK_MOD_EN_IN,
  output logic             RECORD_PROC_EN_OUT,
  output logic             RECORD_MOD_EN_OUT,
  output logic             RECORD_SAMPLE_EN_OUT,
  output logic             PLAYBACK_CFG_VALID_OUT,
  output logic [4:0]       PLAYBACK_INTERP_OUT,
  output logic             RECORD_CFG_VALID_OUT,
  output logic [8:0]       RECORD_INSTR_COUNT_OUT,
  output logic [4:0]       RECORD_DECIM_OUT
);

  function automatic logic [8:0] zero_is_max(input logic [7:0] code,
                                             input logic [8:0] maxv);
    if (code == 8'h00) begin
      return maxv;
    end
    return {1'b0, code};
  endfunction

  function automatic logic sel_programmable(input logic [4:0] sel);
    return (sel == acdc_pkg::SEL_PROGRAMMABLE);
  endfunction

  acdc_pkg::acdc_state_t state_r;
  acdc_pkg::acdc_state_t state_nxt;
  logic [7:0]            interp_r;
  logic [7:0]            interp_nxt;
  logic [7:0]            first_r;
  logic [7:0]            first_nxt;
  logic [7:0]            mod_r;
  logic [7:0]            mod_nxt;
  logic [7:0]            osr_r;
  logic [7:0]            osr_nxt;
  logic [7:0]            instr_r;
  logic [7:0]            instr_nxt;
  logic [7:0]            decim_r;
  logic [7:0]            decim_nxt;
  logic [4:0]            pb_sel_r;
  logic [4:0]            pb_sel_nxt;
  logic [4:0]            rec_sel_r;
  logic [4:0]            rec_sel_nxt;
  logic [31:0]           rdata_r;
  logic [31:0]           rdata_nxt;
  logic                  err_r;
  logic                  err_nxt;
  acdc_pkg::acdc_cfg_t   cfg_r;
  acdc_pkg::acdc_cfg_t   cfg_nxt;
  logic [5:0]            idx;
  logic                  mapped;
  logic [7:0]            rd_byte;
  logic                  access;
  logic                  wr_fire;

  assign idx = PADDR_IN[7:2];
  assign access = PSEL_IN && PENABLE_IN;
  assign wr_fire = access && PWRITE_IN && (state_r == acdc_pkg::ACDC_ST_DONE) && mapped;

  // Read mux and address decode; reserved bits and the reserved register read as zero.
  always_comb begin
    mapped = (PADDR_IN[1:0] == 2'b00);
    rd_byte = 8'h00;
    case (idx)
      acdc_pkg::IDX_PLAYBACK_INTERP_RATIO: begin
        rd_byte = interp_r;
      end
      acdc_pkg::IDX_RESERVED_INDEX_17: begin
        rd_byte = 8'h00;
      end
      acdc_pkg::IDX_RECORD_FIRST_DIVIDER: begin
        rd_byte = first_r;
      end
      acdc_pkg::IDX_RECORD_MODULATOR_DIVIDER: begin
        rd_byte = mod_r;
      end
      acdc_pkg::IDX_RECORD_OVERSAMPLE_RATIO: begin
        rd_byte = osr_r;
      end
      acdc_pkg::IDX_RECORD_INSTRUCTION_COUNT: begin
        rd_byte = instr_r;
      end
      acdc_pkg::IDX_RECORD_DECIM_RATIO: begin
        rd_byte = decim_r;
      end
      acdc_pkg::IDX_PLAYBACK_BLOCK_SEL: begin
        rd_byte = {3'h0, pb_sel_r};
      end
      acdc_pkg::IDX_RECORD_BLOCK_SEL: begin
        rd_byte = {3'h0, rec_sel_r};
      end
      default: begin
        mapped = 1'b0;
      end
    endcase
  end

  // Bus slave: one wait cycle, then the answer stands for one cycle.
  always_comb begin
    state_nxt = state_r;
    rdata_nxt = rdata_r;
    err_nxt = err_r;
    case (state_r)
      acdc_pkg::ACDC_ST_IDLE: begin
        if (access) begin
          state_nxt = acdc_pkg::ACDC_ST_DONE;
          if (PWRITE_IN || !mapped) begin
            rdata_nxt = 32'h0000_0000;
          end else begin
            rdata_nxt = {24'h00_0000, rd_byte};
          end
          err_nxt = !mapped;
        end
      end
      acdc_pkg::ACDC_ST_DONE: begin
        state_nxt = acdc_pkg::ACDC_ST_IDLE;
        err_nxt = 1'b0;
      end
      default: begin
        state_nxt = acdc_pkg::ACDC_ST_IDLE;
      end
    endcase
  end

  // Register writes; only defined bits are stored.
  always_comb begin
    interp_nxt = interp_r;
    first_nxt = first_r;
    mod_nxt = mod_r;
    osr_nxt = osr_r;
    instr_nxt = instr_r;
    decim_nxt = decim_r;
    pb_sel_nxt = pb_sel_r;
    rec_sel_nxt = rec_sel_r;
    if (wr_fire) begin
      case (idx)
        acdc_pkg::IDX_PLAYBACK_INTERP_RATIO: begin
          interp_nxt = PWDATA_IN[7:0] & acdc_pkg::RATIO4_MASK;
        end
        acdc_pkg::IDX_RECORD_FIRST_DIVIDER: begin
          first_nxt = PWDATA_IN[7:0];
        end
        acdc_pkg::IDX_RECORD_MODULATOR_DIVIDER: begin
          mod_nxt = PWDATA_IN[7:0];
        end
        acdc_pkg::IDX_RECORD_OVERSAMPLE_RATIO: begin
          osr_nxt = PWDATA_IN[7:0];
        end
        acdc_pkg::IDX_RECORD_INSTRUCTION_COUNT: begin
          instr_nxt = PWDATA_IN[7:0];
        end
        acdc_pkg::IDX_RECORD_DECIM_RATIO: begin
          decim_nxt = PWDATA_IN[7:0] & acdc_pkg::RATIO4_MASK;
        end
        acdc_pkg::IDX_PLAYBACK_BLOCK_SEL: begin
          pb_sel_nxt = 5'(PWDATA_IN[7:0] & acdc_pkg::SEL5_MASK);
        end
        acdc_pkg::IDX_RECORD_BLOCK_SEL: begin
          rec_sel_nxt = 5'(PWDATA_IN[7:0] & acdc_pkg::SEL5_MASK);
        end
        default: begin
        end
      endcase
    end
  end

  // Decoded configuration for the processing engines.
  always_comb begin
    cfg_nxt.playback_interp = 5'(zero_is_max(interp_r & acdc_pkg::RATIO4_MASK,
                                             acdc_pkg::MAX_RATIO4));
    cfg_nxt.playback_valid = sel_programmable(pb_sel_r);
    cfg_nxt.record_instr = {instr_r, 1'b0};
    cfg_nxt.record_decim = 5'(zero_is_max(decim_r & acdc_pkg::RATIO4_MASK,
                                          acdc_pkg::MAX_RATIO4));
    cfg_nxt.record_valid = sel_programmable(rec_sel_r);
  end

  always_ff @(posedge SYS_CLK_IN or posedge RST_IN) begin
    if (RST_IN) begin
      state_r <= acdc_pkg::ACDC_ST_IDLE;
      rdata_r <= 32'h0000_0000;
      err_r <= 1'b0;
    end else begin
      state_r <= state_nxt;
      rdata_r <= rdata_nxt;
      err_r <= err_nxt;
    end
  end

  always_ff @(posedge SYS_CLK_IN or posedge RST_IN) begin
    if (RST_IN) begin
      interp_r <= acdc_pkg::RST_PLAYBACK_INTERP_RATIO;
      first_r <= acdc_pkg::RST_RECORD_FIRST_DIVIDER;
      mod_r <= acdc_pkg::RST_RECORD_MODULATOR_DIVIDER;
      osr_r <= acdc_pkg::RST_RECORD_OVERSAMPLE_RATIO;
      instr_r <= acdc_pkg::RST_RECORD_INSTRUCTION_COUNT;
      decim_r <= acdc_pkg::RST_RECORD_DECIM_RATIO;
      pb_sel_r <= acdc_pkg::RST_BLOCK_SEL;
      rec_sel_r <= acdc_pkg::RST_BLOCK_SEL;
    end else begin
      interp_r <= interp_nxt;
      first_r <= first_nxt;
      mod_r <= mod_nxt;
      osr_r <= osr_nxt;
      instr_r <= instr_nxt;
      decim_r <= decim_nxt;
      pb_sel_r <= pb_sel_nxt;
      rec_sel_r <= rec_sel_nxt;
    end
  end

  always_ff @(posedge SYS_CLK_IN or posedge RST_IN) begin
    if (RST_IN) begin
      cfg_r <= '0;
    end else begin
      cfg_r <= cfg_nxt;
    end
  end

  assign PREADY_OUT = (state_r == acdc_pkg::ACDC_ST_DONE);
  assign PSLVERR_OUT = PREADY_OUT && err_r;
  assign PRDATA_OUT = rdata_r;
  assign PLAYBACK_CFG_VALID_OUT = cfg_r.playback_valid;
  assign PLAYBACK_INTERP_OUT = cfg_r.playback_interp;
  assign RECORD_CFG_VALID_OUT = cfg_r.record_valid;
  assign RECORD_INSTR_COUNT_OUT = cfg_r.record_instr;
  assign RECORD_DECIM_OUT = cfg_r.record_decim;

  logic [acdc_pkg::NUM_STAGES-1:0] stg_power;
  logic [acdc_pkg::NUM_STAGES-1:0] stg_tick_in;
  logic [acdc_pkg::NUM_STAGES-1:0] stg_tick_out;
  logic [8:0]                      stg_ratio [acdc_pkg::NUM_STAGES];
  logic                            proc_en;
  logic                            mod_en;

  assign stg_power[0] = first_r[acdc_pkg::DIV_POWER_BIT];
  assign proc_en = stg_power[0] ? stg_tick_out[0] : PLAYBACK_PROC_EN_IN;
  assign stg_power[1] = mod_r[acdc_pkg::DIV_POWER_BIT];
  assign mod_en = stg_power[1] ? stg_tick_out[1] : PLAYBACK_MOD_EN_IN;

  assign stg_power[2] = 1'b1;

  assign stg_tick_in[0] = CODEC_CLK_EN_IN;
  assign stg_tick_in[1] = proc_en;
  assign stg_tick_in[2] = mod_en;
  assign stg_ratio[0] = zero_is_max(first_r & acdc_pkg::DIV7_MASK, acdc_pkg::MAX_DIV7);
  assign stg_ratio[1] = zero_is_max(mod_r & acdc_pkg::DIV7_MASK, acdc_pkg::MAX_DIV7);
  assign stg_ratio[2] = zero_is_max(osr_r, acdc_pkg::MAX_RATIO8);

  for (genvar g = 0; g < acdc_pkg::NUM_STAGES; g++) begin : g_stage
    acdc_div acdc_div_i (
      .clk_in   (SYS_CLK_IN),
      .rst_in   (RST_IN),
      .power_in (stg_power[g]),
      .tick_in  (stg_tick_in[g]),
      .ratio_in (stg_ratio[g]),
      .tick_out (stg_tick_out[g])
    );
  end

  assign RECORD_PROC_EN_OUT = proc_en;
  assign RECORD_MOD_EN_OUT = mod_en;
  assign RECORD_SAMPLE_EN_OUT = stg_tick_out[2];

endmodule

`default_nettype wire

//--- src/acdc_pkg.sv
`default_nettype none
package acdc_pkg;

  // Register indices; the byte address is four times the index.
  localparam logic [5:0] IDX_PLAYBACK_INTERP_RATIO     = 6'h0F;
  localparam logic [5:0] IDX_RESERVED_INDEX_17         = 6'h11;
  localparam logic [5:0] IDX_RECORD_FIRST_DIVIDER      = 6'h12;
  localparam logic [5:0] IDX_RECORD_MODULATOR_DIVIDER  = 6'h13;
  localparam logic [5:0] IDX_RECORD_OVERSAMPLE_RATIO   = 6'h14;
  localparam logic [5:0] IDX_RECORD_INSTRUCTION_COUNT  = 6'h15;
  localparam logic [5:0] IDX_RECORD_DECIM_RATIO        = 6'h16;
  localparam logic [5:0] IDX_PLAYBACK_BLOCK_SEL        = 6'h3C;
  localparam logic [5:0] IDX_RECORD_BLOCK_SEL          = 6'h3D;

  // Reset values.
  localparam logic [7:0] RST_PLAYBACK_INTERP_RATIO     = 8'h08;
  localparam logic [7:0] RST_RECORD_FIRST_DIVIDER      = 8'h01;
  localparam logic [7:0] RST_RECORD_MODULATOR_DIVIDER  = 8'h01;
  localparam logic [7:0] RST_RECORD_OVERSAMPLE_RATIO   = 8'h80;
  localparam logic [7:0] RST_RECORD_INSTRUCTION_COUNT  = 8'h80;
  localparam logic [7:0] RST_RECORD_DECIM_RATIO        = 8'h04;
  localparam logic [4:0] RST_BLOCK_SEL                 = 5'h00;

  // Field positions and masks.
  localparam int         DIV_POWER_BIT                 = 7;
  localparam logic [7:0] RATIO4_MASK                   = 8'h0F;
  localparam logic [7:0] DIV7_MASK                     = 8'h7F;
  localparam logic [7:0] SEL5_MASK                     = 8'h1F;
  localparam logic [4:0] SEL_PROGRAMMABLE              = 5'h00;

  // Value of a zero code for each field width.
  localparam logic [8:0] MAX_RATIO4                    = 9'h010;
  localparam logic [8:0] MAX_DIV7                      = 9'h080;
  localparam logic [8:0] MAX_RATIO8                    = 9'h100;

  localparam int         NUM_STAGES                    = 3;

  typedef enum logic [1:0] {
    ACDC_ST_IDLE = 2'b00,
    ACDC_ST_DONE = 2'b01
  } acdc_state_t;

  typedef struct packed {
    logic       playback_valid;
    logic [4:0] playback_interp;
    logic       record_valid;
    logic [8:0] record_instr;
    logic [4:0] record_decim;
  } acdc_cfg_t;

endpackage
`default_nettype wire

//--- src/acdc_div.sv
`timescale 1ns/100ps
`default_nettype none

module acdc_div (
  input  wire logic       clk_in,
  input  wire logic       rst_in,
  input  wire logic       power_in,
  input  wire logic       tick_in,
  input  wire logic [8:0] ratio_in,
  output logic            tick_out
);

  logic [7:0] cnt_r;
  logic [7:0] cnt_nxt;
  logic       tick_r;
  logic       tick_nxt;
  logic [7:0] last;

  assign last = 8'(ratio_in - 9'h001);

  // Counts input ticks and pulses once per ratio ticks; idle when powered down.
  always_comb begin
    cnt_nxt = cnt_r;
    tick_nxt = 1'b0;
    if (!power_in) begin
      cnt_nxt = 8'h00;
    end else if (tick_in) begin
      if (cnt_r == last) begin
        cnt_nxt = 8'h00;
        tick_nxt = 1'b1;
      end else begin
        cnt_nxt = cnt_r + 8'h01;
      end
    end
  end

  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      cnt_r <= 8'h00;
      tick_r <= 1'b0;
    end else begin
      cnt_r <= cnt_nxt;
      tick_r <= tick_nxt;
    end
  end

  assign tick_out = tick_r;

endmodule

`default_nettype wire

//--- verif/acdc_top_checker.sv
`timescale 1ns/100ps
`default_nettype none
module acdc_top_checker (
  input wire logic        SYS_CLK_IN,
  input wire logic        RST_IN,
  input wire logic        PSEL_IN,
  input wire logic        PENABLE_IN,
  input wire logic        PWRITE_IN,
  input wire logic [7:0]  PADDR_IN,
  input wire logic [31:0] PWDATA_IN,
  input wire logic [31:0] PRDATA_OUT,
  input wire logic        PREADY_OUT,
  input wire logic        PSLVERR_OUT,
  input wire logic        PLAYBACK_MOD_EN_IN,
  input wire logic        RECORD_PROC_EN_OUT,
  input wire logic        RECORD_MOD_EN_OUT,
  input wire logic        RECORD_SAMPLE_EN_OUT,
  input wire logic        PLAYBACK_CFG_VALID_OUT,
  input wire logic [4:0]  PLAYBACK_INTERP_OUT,
  input wire logic        RECORD_CFG_VALID_OUT,
  input wire logic [8:0]  RECORD_INSTR_COUNT_OUT,
  input wire logic [4:0]  RECORD_DECIM_OUT
);
  default clocking cb @(posedge SYS_CLK_IN);
  endclocking
  default disable iff (RST_IN);

  function automatic logic [4:0] dec4(input logic [3:0] c);
    return (c == 4'h0) ? 5'h10 : {1'b0, c};
  endfunction

  sequence wr_done(logic [7:0] a);
    PSEL_IN && PENABLE_IN && PWRITE_IN && PREADY_OUT && !PSLVERR_OUT && PADDR_IN == a;
  endsequence

  sequence setup_access;
    PSEL_IN && !PENABLE_IN ##1 PSEL_IN && PENABLE_IN;
  endsequence

  a_ready_single: assert property (PREADY_OUT |=> !PREADY_OUT)
    else $error("ready longer than one cycle");
  a_wait_state: assert property (setup_access |-> !PREADY_OUT ##1 PREADY_OUT)
    else $error("ready not after one wait state");
  a_err_reads_zero: assert property (PREADY_OUT && PSLVERR_OUT |-> PRDATA_OUT == 32'h0)
    else $error("error read not zero");
  a_interp_decode: assert property (
    wr_done(8'h3C) |-> ##2 PLAYBACK_INTERP_OUT == dec4($past(PWDATA_IN[3:0], 2)))
    else $error("interpolation decode wrong");
  a_decim_decode: assert property (
    wr_done(8'h58) |-> ##2 RECORD_DECIM_OUT == dec4($past(PWDATA_IN[3:0], 2)))
    else $error("decimation decode wrong");
  a_instr_double: assert property (
    wr_done(8'h54) |-> ##2 RECORD_INSTR_COUNT_OUT == {$past(PWDATA_IN[7:0], 2), 1'b0})
    else $error("instruction count wrong");
  a_pb_valid: assert property (
    wr_done(8'hF0) |-> ##2 PLAYBACK_CFG_VALID_OUT == ($past(PWDATA_IN[4:0], 2) == 5'h00))
    else $error("playback valid wrong");
  a_rec_valid: assert property (
    wr_done(8'hF4) |-> ##2 RECORD_CFG_VALID_OUT == ($past(PWDATA_IN[4:0], 2) == 5'h00))
    else $error("record valid wrong");
  a_mod_source: assert property (
    RECORD_MOD_EN_OUT |-> $past(RECORD_PROC_EN_OUT) || PLAYBACK_MOD_EN_IN)
    else $error("modulator tick without source");
  a_sample_source: assert property (
    RECORD_SAMPLE_EN_OUT |-> $past(RECORD_MOD_EN_OUT))
    else $error("sample tick without modulator tick");
endmodule

bind acdc_top acdc_top_checker acdc_top_checker_i (
  .SYS_CLK_IN(SYS_CLK_IN), .RST_IN(RST_IN), .PSEL_IN(PSEL_IN), .PENABLE_IN(PENABLE_IN),
  .PWRITE_IN(PWRITE_IN), .PADDR_IN(PADDR_IN), .PWDATA_IN(PWDATA_IN),
  .PRDATA_OUT(PRDATA_OUT), .PREADY_OUT(PREADY_OUT), .PSLVERR_OUT(PSLVERR_OUT),
  .PLAYBACK_MOD_EN_IN(PLAYBACK_MOD_EN_IN), .RECORD_PROC_EN_OUT(RECORD_PROC_EN_OUT),
  .RECORD_MOD_EN_OUT(RECORD_MOD_EN_OUT), .RECORD_SAMPLE_EN_OUT(RECORD_SAMPLE_EN_OUT),
  .PLAYBACK_CFG_VALID_OUT(PLAYBACK_CFG_VALID_OUT), .PLAYBACK_INTERP_OUT(PLAYBACK_INTERP_OUT),
  .RECORD_CFG_VALID_OUT(RECORD_CFG_VALID_OUT),
  .RECORD_INSTR_COUNT_OUT(RECORD_INSTR_COUNT_OUT), .RECORD_DECIM_OUT(RECORD_DECIM_OUT)
);
`default_nettype wire

//--- verif/tb_acdc_top.sv
`timescale 1ns/100ps
`default_nettype none
module tb_acdc_top;
  logic        clk = 1'b0;
  logic        rst = 1'b1;
  logic        psel = 1'b0;
  logic        pen = 1'b0;
  logic        pwr = 1'b0;
  logic        cce = 1'b0;
  logic        ppe = 1'b0;
  logic        pme = 1'b0;
  logic [7:0]  pa = 8'h00;
  logic [31:0] pwd = 32'h0;
  logic [31:0] prd;
  logic [31:0] rd;
  logic        rdy, err, e, rpe, rme, rse, pbv, rcv;
  logic [4:0]  pbi, rdc;
  logic [8:0]  rin;
  int          miscompares = 0;
  int          checks = 0;
  int          cyc = 0;

  always #50 clk = ~clk;

  acdc_top acdc_top_i (
    .SYS_CLK_IN(clk), .RST_IN(rst), .PSEL_IN(psel), .PENABLE_IN(pen), .PWRITE_IN(pwr),
    .PADDR_IN(pa), .PWDATA_IN(pwd), .PRDATA_OUT(prd), .PREADY_OUT(rdy), .PSLVERR_OUT(err),
    .CODEC_CLK_EN_IN(cce), .PLAYBACK_PROC_EN_IN(ppe), .PLAYBACK_MOD_EN_IN(pme),
    .RECORD_PROC_EN_OUT(rpe), .RECORD_MOD_EN_OUT(rme), .RECORD_SAMPLE_EN_OUT(rse),
    .PLAYBACK_CFG_VALID_OUT(pbv), .PLAYBACK_INTERP_OUT(pbi), .RECORD_CFG_VALID_OUT(rcv),
    .RECORD_INSTR_COUNT_OUT(rin), .RECORD_DECIM_OUT(rdc)
  );

  task summarize;
    $display("checks %0d miscompares %0d", checks, miscompares);
    if (miscompares == 0 && checks > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  task chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      miscompares++;
      $display("BAD %0t got %h expected %h", $time, got, exp);
    end
  endtask

  // One APB transfer; read data and error are taken at the edge that samples ready high.
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    psel <= 1'b1;
    pen <= 1'b0;
    pwr <= w;
    pa <= a;
    pwd <= d;
    @(posedge clk);
    pen <= 1'b1;
    @(posedge clk);
    while (rdy !== 1'b1)
      @(posedge clk);
    rd = prd;
    e = err;
    psel <= 1'b0;
    pen <= 1'b0;
  endtask

  task settle;
    @(posedge clk);
    @(negedge clk);
  endtask

  task t_regs;
    logic [7:0] ad [9];
    logic [7:0] rv [9];
    ad = '{8'h3C, 8'h44, 8'h48, 8'h4C, 8'h50, 8'h54, 8'h58, 8'hF0, 8'hF4};
    rv = '{8'h08, 8'h00, 8'h01, 8'h01, 8'h80, 8'h80, 8'h04, 8'h00, 8'h00};
    @(posedge clk);
    @(negedge clk);
    chk(pbi, 32'h8);
    chk(rin, 32'h100);
    chk(rdc, 32'h4);
    chk({pbv, rcv}, 32'h3);
    for (int i = 0; i < 9; i++) begin
      apb(1'b0, ad[i], 32'h0);
      chk(rd, {24'h0, rv[i]});
      chk({31'h0, e}, 32'h0);
    end
    apb(1'b1, 8'h40, 32'hFF);
    chk({31'h0, e}, 32'h1);
    apb(1'b0, 8'h44, 32'h0);
    chk(rd, 32'h0);
    chk({31'h0, e}, 32'h0);
    apb(1'b0, 8'h40, 32'h0);
    chk(rd, 32'h0);
    chk({31'h0, e}, 32'h1);
    apb(1'b1, 8'h49, 32'h85);
    chk({31'h0, e}, 32'h1);
    apb(1'b0, 8'h49, 32'h0);
    chk(rd, 32'h0);
    apb(1'b0, 8'h48, 32'h0);
    chk(rd, 32'h1);
    apb(1'b1, 8'h3C, 32'h05);
    apb(1'b0, 8'h3C, 32'h0);
    chk(rd, 32'h5);
  endtask

  task t_bypass;
    @(posedge clk);
    ppe <= 1'b1;
    pme <= 1'b1;
    @(negedge clk);
    chk({rpe, rme}, 32'h3);
    @(posedge clk);
    ppe <= 1'b0;
    pme <= 1'b0;
    @(negedge clk);
    chk({rpe, rme}, 32'h0);
  endtask

  task t_ratio4;
    for (int c = 0; c < 16; c++) begin
      apb(1'b1, 8'h58, 32'h1);
      apb(1'b1, 8'h50, c);
      apb(1'b1, 8'h54, (c == 0) ? 8 : c);
      apb(1'b1, 8'h3C, c);
      apb(1'b1, 8'h58, c);
      settle;
      chk(pbi, (c == 0) ? 16 : c);
      chk(rdc, (c == 0) ? 16 : c);
      chk(rin, (c == 0) ? 16 : 2 * c);
    end
  endtask

  task t_instr;
    logic [7:0] cd [3];
    cd = '{8'h01, 8'hC0, 8'h80};
    apb(1'b1, 8'h58, 32'h1);
    for (int i = 0; i < 3; i++) begin
      apb(1'b1, 8'h54, {24'h0, cd[i]});
      settle;
      chk(rin, {cd[i], 1'b0});
    end
  endtask

  task t_select;
    apb(1'b1, 8'hF0, 32'h01);
    apb(1'b1, 8'hF4, 32'h1F);
    settle;
    chk({pbv, rcv}, 32'h0);
    apb(1'b1, 8'hF0, 32'h00);
    apb(1'b1, 8'hF4, 32'h00);
    settle;
    chk({pbv, rcv}, 32'h3);
  endtask

  task t_chain(input logic [7:0] f, input logic [7:0] m, input logic [7:0] o,
               input int n, input int ep, input int em, input int es);
    logic [31:0] np, nm, ns;
    np = 0;
    nm = 0;
    ns = 0;
    apb(1'b1, 8'h48, {24'h0, f});
    apb(1'b1, 8'h4C, {24'h0, m});
    apb(1'b1, 8'h50, {24'h0, o});
    for (int i = 0; i < n + 6; i++) begin
      @(posedge clk);
      cce <= (i < n);
      @(negedge clk);
      np += rpe;
      nm += rme;
      ns += rse;
    end
    chk(np, ep);
    chk(nm, em);
    chk(ns, es);
  endtask

  always @(posedge clk) begin
    cyc++;
    if (cyc == 5000) begin
      miscompares++;
      summarize;
    end
  end

  initial begin
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    t_regs;
    t_bypass;
    t_ratio4;
    t_instr;
    t_select;
    t_chain(8'h82, 8'h83, 8'h02, 120, 60, 20, 10);
    t_chain(8'h80, 8'h01, 8'h02, 256, 2, 0, 0);
    t_chain(8'h81, 8'h81, 8'h00, 512, 512, 512, 2);
    summarize;
  end
endmodule
`default_nettype wire
